// ---- adhp_pkg.sv ----
// Shared constants and types for the ATA device host port
package adhp_pkg;
	// Bus widths and buffering
	localparam int DATA_W     = 16;
	localparam int TASK_W     = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int RX_MARGIN  = 4;
	// Ultra DMA read strobe pacing
	localparam int CLK_MHZ        = 100;
	localparam int T_UDMA_HALF_NS = 60;
	localparam int UDMA_HALF_CYC  = (T_UDMA_HALF_NS * CLK_MHZ + 999) / 1000;
	// Register addresses inside a chip-select group
	localparam logic [2:0] DA_DATA     = 3'h0;
	localparam logic [2:0] DA_DEVCTL   = 3'h6;
	localparam logic [2:0] DA_CMD_STAT = 3'h7;
	localparam int         NIEN_BIT    = 1;
	// Reset values
	localparam logic NIEN_RST    = 1'b0;
	localparam logic DSTROBE_RST = 1'b1;
	// Packed pin vector layout
	localparam int PIN_W     = 25;
	localparam int PIN_DD    = 0;
	localparam int PIN_DA    = 16;
	localparam int PIN_CS0   = 19;
	localparam int PIN_CS1   = 20;
	localparam int PIN_DMACK = 21;
	localparam int PIN_DIOR  = 22;
	localparam int PIN_DIOW  = 23;
	localparam int PIN_RST   = 24;
	localparam logic [PIN_W-1:0] PIN_IDLE = 25'h1F80000;
	// Transfer phase of the shared strobe lines
	typedef enum logic [1:0] {
		PH_REG     = 2'b00,
		PH_MDMA    = 2'b01,
		PH_UDMA_WR = 2'b10,
		PH_UDMA_RD = 2'b11
	} adhp_phase_type;
endpackage

// ---- adhp_fifo.sv ----
// Synchronous valid/ready FIFO used in both data directions
`timescale 1ns/100ps
module adhp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH),
	localparam int CW = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Filling side
	input  wire logic [WIDTH-1:0] s_data_i,
	input  wire logic             s_valid_i,
	output wire logic             s_ready_o,
	// Draining side
	output wire logic [WIDTH-1:0] m_data_o,
	output wire logic             m_valid_o,
	input  wire logic             m_ready_i,
	// Fill level
	output wire logic [CW-1:0]    level_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    level;

	// Handshake decode
	wire push = s_valid_i & s_ready_o;
	wire pop  = m_valid_o & m_ready_i;
	assign s_ready_o = level != CW'(DEPTH);
	assign m_valid_o = level != '0;
	assign m_data_o  = mem[rd_ptr];
	assign level_o   = level;

	// Storage needs no reset, only the pointers and level do
	always_ff @(posedge clk_i) begin
		if (push) mem[wr_ptr] <= s_data_i;
	end

	// Pointers wrap explicitly so any depth works
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
	end

	// Level tracks simultaneous push and pop
	always_ff @(posedge clk_i) begin
		if (rst_i) level <= '0;
		else if (push & ~pop) level <= level + 1'b1;
		else if (pop & ~push) level <= level - 1'b1;
	end
endmodule // adhp_fifo

// ---- adhp_host_port.sv ----
// Device end of the parallel ATA host port: PIO, multiword and Ultra DMA
//
// Summary of operation
// R1: Host holds reset low during power-up and supply faults.
// R2: Data register accesses move a full 16-bit word.
// R3: All other register accesses use only data bits 7 to 0.
// R4: Device raises DMA request when ready, handshaken with host acknowledge.
// R5: In multiword DMA the host picks direction by toggling write or read strobe.
// R6: Write strobe rising edge captures the bus into register or data.
// R7: Host raises STOP on the write strobe line to end a burst.
// R8: While read strobe is low the device drives the addressed data.
// R9: Host captures read data on the read strobe rising edge.
// R10: In Ultra DMA read the host signals readiness on the read line.
// R11: Ultra DMA write latches one word on each host strobe edge.
// R12: Ready line tells the host whether a PIO cycle can complete.
// R13: In Ultra DMA write device signals readiness on the ready line.
// R14: Ultra DMA read toggles device strobe, one word per edge.
// R15: Host answers DMA request with acknowledge when ready.
// R16: Interrupt is driven only when selected and enabled, else released.
// R17: Pending interrupt clears on status read, command write or DRQ drop.
// R18: Chip selects pick register group, address lines pick the register.
// R19: Data bus released except while returning read data.
// R20: Shared strobe lines change meaning with the transfer phase.
`timescale 1ns/100ps
module adhp_host_port #(
	parameter int DATA_W     = adhp_pkg::DATA_W,
	parameter int FIFO_DEPTH = adhp_pkg::FIFO_DEPTH,
	localparam int LW = $clog2(FIFO_DEPTH + 1)
) (
	// Clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_I,
	// Host cable inputs
	input  wire logic              RESET_N_I,
	input  wire logic              DIOW_N_I,
	input  wire logic              DIOR_N_I,
	input  wire logic              DMACK_N_I,
	input  wire logic              CS0_N_I,
	input  wire logic              CS1_N_I,
	input  wire logic [2:0]        DA_I,
	input  wire logic [DATA_W-1:0] DD_I,
	// Host cable outputs
	output wire logic [DATA_W-1:0] DD_O,
	output wire logic              DD_OE_N_O,
	output wire logic              DMARQ_O,
	output wire logic              IORDY_O,
	output wire logic              IORDY_OE_N_O,
	output wire logic              INTRQ_O,
	output wire logic              INTRQ_OE_N_O,
	// Drive-side control
	input  wire logic              DEV_SEL_I,
	input  wire logic              IRQ_SET_I,
	input  wire logic              DRQ_I,
	input  wire logic              DMA_EN_I,
	input  wire logic              DMA_WRITE_I,
	input  wire logic              UDMA_I,
	// Task register access
	output wire logic              REG_WR_O,
	output wire logic              REG_RD_O,
	output wire logic              REG_CS1_O,
	output wire logic [2:0]        REG_DA_O,
	output wire logic [7:0]        REG_WDATA_O,
	input  wire logic [7:0]        REG_RDATA_I,
	// Host-to-drive data stream
	output wire logic [DATA_W-1:0] RX_DATA_O,
	output wire logic              RX_VALID_O,
	input  wire logic              RX_READY_I,
	// Drive-to-host data stream
	input  wire logic [DATA_W-1:0] TX_DATA_I,
	input  wire logic              TX_VALID_I,
	output wire logic              TX_READY_O,
	// Status
	output wire logic              HOST_RESET_O,
	output wire logic              IRQ_PEND_O,
	output wire logic [1:0]        PHASE_O
);
	localparam int TW = adhp_pkg::TASK_W;
	localparam logic [3:0] DIV_LAST = 4'(adhp_pkg::UDMA_HALF_CYC - 1);
	localparam logic [LW-1:0] RX_ROOM_LVL =
		LW'(FIFO_DEPTH - adhp_pkg::RX_MARGIN);

	// One group selected, matching group and register
	function automatic logic reg_hit(input logic c0, input logic c1,
			input logic [2:0] a, input logic want_c1,
			input logic [2:0] want_a);
		reg_hit = (c0 ^ c1) && (c1 == want_c1) && (a == want_a);
	endfunction

	logic [adhp_pkg::PIN_W-1:0] pin_s1;
	logic [adhp_pkg::PIN_W-1:0] pin_s2;
	logic [adhp_pkg::PIN_W-1:0] pin_q;
	adhp_pkg::adhp_phase_type   phase;
	adhp_pkg::adhp_phase_type   next_phase;
	logic [DATA_W-1:0]          dd_out;
	logic                       dd_oe_n;
	logic                       dmarq;
	logic                       iordy;
	logic                       iordy_oe_n;
	logic                       irq_pend;
	logic                       intrq_oe_n;
	logic                       nien;
	logic                       drq_q;
	logic [3:0]                 div_cnt;
	logic                       ud_step;
	logic                       dstrobe;
	logic [DATA_W-1:0]          tx_data;
	logic                       tx_valid;
	logic                       rx_ready;
	logic [LW-1:0]              rx_level;

	// Every cable pin passes two flops; pin_q is a third for edges
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			pin_s1 <= adhp_pkg::PIN_IDLE;
			pin_s2 <= adhp_pkg::PIN_IDLE;
			pin_q  <= adhp_pkg::PIN_IDLE;
		end else begin
			pin_s1 <= {RESET_N_I, DIOW_N_I, DIOR_N_I, DMACK_N_I,
				CS1_N_I, CS0_N_I, DA_I, DD_I};
			pin_s2 <= pin_s1;
			pin_q  <= pin_s2;
		end
	end

	// Strobe edges; data and address come from the older sample
	wire diow_rise = pin_s2[adhp_pkg::PIN_DIOW] & ~pin_q[adhp_pkg::PIN_DIOW];
	wire dior_rise = pin_s2[adhp_pkg::PIN_DIOR] & ~pin_q[adhp_pkg::PIN_DIOR];
	wire strb_edge = pin_s2[adhp_pkg::PIN_DIOR] ^ pin_q[adhp_pkg::PIN_DIOR];
	wire dior_low  = ~pin_q[adhp_pkg::PIN_DIOR];
	wire diow_low  = ~pin_q[adhp_pkg::PIN_DIOW];
	wire dmack     = ~pin_q[adhp_pkg::PIN_DMACK];
	wire cs0       = ~pin_q[adhp_pkg::PIN_CS0];
	wire cs1       = ~pin_q[adhp_pkg::PIN_CS1];
	wire [2:0] da  = pin_q[adhp_pkg::PIN_DA +: 3];
	wire [DATA_W-1:0] dd = pin_q[adhp_pkg::PIN_DD +: DATA_W];
	wire host_rst  = ~pin_q[adhp_pkg::PIN_RST];
	wire blk_rst   = RST_I | host_rst; // [R1]

	// Register decode
	wire sel      = cs0 ^ cs1; // [R18]
	wire hit_data = reg_hit(cs0, cs1, da, 1'b0, adhp_pkg::DA_DATA); // [R18]
	wire hit_cmd  = reg_hit(cs0, cs1, da, 1'b0, adhp_pkg::DA_CMD_STAT);
	wire hit_ctl  = reg_hit(cs0, cs1, da, 1'b1, adhp_pkg::DA_DEVCTL);

	// Phase flags
	wire in_reg  = phase == adhp_pkg::PH_REG;
	wire in_mdma = phase == adhp_pkg::PH_MDMA;
	wire in_udwr = phase == adhp_pkg::PH_UDMA_WR;
	wire in_udrd = phase == adhp_pkg::PH_UDMA_RD;
	wire hdmardy = in_udrd & dior_low; // [R10]

	// Phase selects what the shared lines mean
	always_comb begin
		next_phase = phase;
		case (phase)
			adhp_pkg::PH_REG: begin
				if (DMA_EN_I && dmack) begin // [R15]
					if (!UDMA_I) next_phase = adhp_pkg::PH_MDMA;
					else if (DMA_WRITE_I) next_phase = adhp_pkg::PH_UDMA_WR;
					else next_phase = adhp_pkg::PH_UDMA_RD;
				end
			end
			adhp_pkg::PH_MDMA: begin
				if (!dmack) next_phase = adhp_pkg::PH_REG;
			end
			adhp_pkg::PH_UDMA_WR, adhp_pkg::PH_UDMA_RD: begin
				if (!dmack || diow_rise) next_phase = adhp_pkg::PH_REG; // [R7]
			end
			default: next_phase = adhp_pkg::PH_REG;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (blk_rst) phase <= adhp_pkg::PH_REG;
		else phase <= next_phase; // [R20]
	end

	// Host writes: data register to FIFO, others to task registers
	wire pio_wr   = in_reg & diow_rise & sel; // [R6]
	wire rx_push  = (pio_wr & hit_data) | (in_mdma & diow_rise) // [R5]
		| (in_udwr & strb_edge); // [R11]
	assign REG_WR_O    = pio_wr & ~hit_data;
	assign REG_CS1_O   = cs1;
	assign REG_DA_O    = da;
	assign REG_WDATA_O = dd[TW-1:0]; // [R3]

	// Pacing tick, declared ahead of the read path that uses it
	wire div_en   = in_udrd & (div_cnt == DIV_LAST);

	// PIO and multiword reads pop the drive-to-host FIFO on strobe release, Ultra DMA reads on a pacing tick
	wire pio_rd   = in_reg & dior_rise & sel;
	wire udma_ld  = div_en & hdmardy & ~ud_step & tx_valid;
	wire tx_pop   = (pio_rd & hit_data) | (in_mdma & dior_rise) | udma_ld;
	assign REG_RD_O = pio_rd & ~hit_data;

	// Data word or zero-extended task register
	wire [DATA_W-1:0] rd_word = (hit_data | in_mdma) ? tx_data // [R2]
		: {{(DATA_W - TW){1'b0}}, REG_RDATA_I}; // [R3]
	wire dd_drive = in_udrd | (dior_low & ((in_reg & sel) | in_mdma)); // [R8]

	// Bus output latch; Ultra DMA holds each word for a full strobe
	always_ff @(posedge CLK_I) begin
		if (blk_rst) begin
			dd_out  <= '0;
			dd_oe_n <= 1'b1;
		end else begin
			dd_oe_n <= ~dd_drive; // [R19]
			if (!in_udrd) dd_out <= rd_word; // [R8]
			else if (udma_ld) dd_out <= tx_data; // [R14]
		end
	end

	// Strobe pacing divider, only counts during Ultra DMA read
	always_ff @(posedge CLK_I) begin
		if (blk_rst | ~in_udrd | div_en) div_cnt <= '0;
		else div_cnt <= div_cnt + 1'b1;
	end

	// Load a word, then toggle the strobe half a period later
	always_ff @(posedge CLK_I) begin
		if (blk_rst | ~in_udrd) begin
			ud_step <= 1'b0;
			dstrobe <= adhp_pkg::DSTROBE_RST;
		end else if (div_en & hdmardy) begin // [R10]
			if (ud_step) begin
				dstrobe <= ~dstrobe; // [R14]
				ud_step <= 1'b0;
			end else if (tx_valid) begin
				ud_step <= 1'b1;
			end
		end
	end

	// Ready line: PIO wait, Ultra DMA pause, or device strobe
	wire rx_room  = rx_level <= RX_ROOM_LVL;
	wire pio_wait = in_reg & hit_data // [R12]
		& ((dior_low & ~tx_valid) | (diow_low & ~rx_ready));
	wire next_iordy = in_udwr ? ~rx_room // [R13]
		: in_udrd ? dstrobe : ~pio_wait;
	wire iordy_drive = in_udwr | in_udrd
		| (in_reg & sel & (dior_low | diow_low)); // [R20]
	always_ff @(posedge CLK_I) begin
		if (blk_rst) begin
			iordy      <= 1'b1;
			iordy_oe_n <= 1'b1;
		end else begin
			iordy      <= next_iordy;
			iordy_oe_n <= ~iordy_drive;
		end
	end

	// Request while the FIFO can take or give a word, and throughout an Ultra DMA burst
	wire next_dmarq = DMA_EN_I & (in_udwr | in_udrd // [R4]
		| (DMA_WRITE_I ? rx_ready : tx_valid));
	always_ff @(posedge CLK_I) begin
		if (blk_rst) dmarq <= 1'b0;
		else dmarq <= next_dmarq;
	end

	// Interrupt: a new event beats a clear in the same cycle
	wire irq_clr = (pio_rd & hit_cmd) | (pio_wr & hit_cmd) // [R17]
		| (drq_q & ~DRQ_I);
	always_ff @(posedge CLK_I) begin
		if (blk_rst) begin
			irq_pend   <= 1'b0;
			drq_q      <= 1'b0;
			nien       <= adhp_pkg::NIEN_RST;
			intrq_oe_n <= 1'b1;
		end else begin
			drq_q <= DRQ_I;
			if (IRQ_SET_I) irq_pend <= 1'b1;
			else if (irq_clr) irq_pend <= 1'b0; // [R17]
			if (pio_wr & hit_ctl) nien <= dd[adhp_pkg::NIEN_BIT];
			intrq_oe_n <= ~(DEV_SEL_I & ~nien); // [R16]
		end
	end

	// Host-to-drive buffer
	adhp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_i     (CLK_I),
		.rst_i     (blk_rst),
		.s_data_i  (dd), // [R2]
		.s_valid_i (rx_push),
		.s_ready_o (rx_ready),
		.m_data_o  (RX_DATA_O),
		.m_valid_o (RX_VALID_O),
		.m_ready_i (RX_READY_I),
		.level_o   (rx_level)
	);

	// Drive-to-host buffer
	adhp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_i     (CLK_I),
		.rst_i     (blk_rst),
		.s_data_i  (TX_DATA_I),
		.s_valid_i (TX_VALID_I),
		.s_ready_o (TX_READY_O),
		.m_data_o  (tx_data),
		.m_valid_o (tx_valid),
		.m_ready_i (tx_pop),
		.level_o   ()
	);

	// Output drive
	assign DD_O         = dd_out;
	assign DD_OE_N_O    = dd_oe_n;
	assign DMARQ_O      = dmarq;
	assign IORDY_O      = iordy;
	assign IORDY_OE_N_O = iordy_oe_n;
	assign INTRQ_O      = irq_pend;
	assign INTRQ_OE_N_O = intrq_oe_n;
	assign HOST_RESET_O = host_rst;
	assign IRQ_PEND_O   = irq_pend;
	assign PHASE_O      = phase;
endmodule // adhp_host_port

// ---- adhp_host_port_props.sv ----
// Concurrent checks on the device host port pins
`timescale 1ns/100ps
module adhp_host_port_props (
	// Clock and reset
	input wire logic       CLK_I,
	input wire logic       RST_I,
	// Watched inputs
	input wire logic       DIOR_N_I,
	input wire logic       DEV_SEL_I,
	input wire logic       IRQ_SET_I,
	input wire logic       DRQ_I,
	input wire logic       DMA_EN_I,
	input wire logic       DMA_WRITE_I,
	input wire logic       UDMA_I,
	// Watched outputs
	input wire logic       DD_OE_N_O,
	input wire logic       DMARQ_O,
	input wire logic       IORDY_O,
	input wire logic       IORDY_OE_N_O,
	input wire logic       INTRQ_OE_N_O,
	input wire logic       IRQ_PEND_O,
	input wire logic       REG_WR_O,
	input wire logic [1:0] PHASE_O
);
	// One clock domain, so clocking and reset are given once
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);

	chk_dmarq_off: assert property (!DMA_EN_I |=> !DMARQ_O)
		else $error("DMA request without drive wanting DMA");
	chk_phase_entry: assert property (
		($past(PHASE_O) == 2'h0 && PHASE_O != 2'h0)
		|-> $past(DMA_EN_I) && PHASE_O == ($past(UDMA_I)
		? ($past(DMA_WRITE_I) ? 2'h2 : 2'h3) : 2'h1))
		else $error("wrong phase entered");
	chk_ddmardy_drive: assert property (
		(PHASE_O == 2'h2 && $past(PHASE_O) == 2'h2) |-> !IORDY_OE_N_O)
		else $error("ready line not driven in burst write");
	chk_udma_oe: assert property (
		(PHASE_O == 2'h3 && $past(PHASE_O) == 2'h3) |-> !DD_OE_N_O)
		else $error("data bus not driven in burst read");
	// A strobe edge is followed by a steady stretch while bursting
	chk_dstrobe_pace: assert property (
		($changed(IORDY_O) && PHASE_O == 2'h3 && $past(PHASE_O) == 2'h3)
		|=> ($stable(IORDY_O) || PHASE_O != 2'h3) [*5])
		else $error("device strobe toggles too fast");
	// Sync delay lets the bus lag the read strobe by a few edges
	chk_ddoe_release: assert property (
		!DD_OE_N_O |-> !($past(DIOR_N_I, 3)
		&& $past(DIOR_N_I, 4) && $past(DIOR_N_I, 5) && $past(DIOR_N_I, 6))
		|| $past(PHASE_O) == 2'h3 || $past(PHASE_O, 2) == 2'h3)
		else $error("data bus driven outside a read");
	chk_intrq_enable: assert property (
		!INTRQ_OE_N_O |-> $past(DEV_SEL_I))
		else $error("interrupt driven while not selected");
	chk_irq_drq: assert property (
		($fell(DRQ_I) && !IRQ_SET_I) |-> ##[1:2] !IRQ_PEND_O)
		else $error("interrupt kept after request drop");
	chk_reg_pulse: assert property (REG_WR_O |=> !REG_WR_O)
		else $error("register write pulse too long");
endmodule // adhp_host_port_props

bind adhp_host_port adhp_host_port_props u_props (
	.CLK_I(CLK_I), .RST_I(RST_I), .DIOR_N_I(DIOR_N_I), .DEV_SEL_I(DEV_SEL_I),
	.IRQ_SET_I(IRQ_SET_I), .DRQ_I(DRQ_I), .DMA_EN_I(DMA_EN_I),
	.DMA_WRITE_I(DMA_WRITE_I), .UDMA_I(UDMA_I), .DD_OE_N_O(DD_OE_N_O),
	.DMARQ_O(DMARQ_O), .IORDY_O(IORDY_O), .IORDY_OE_N_O(IORDY_OE_N_O),
	.INTRQ_OE_N_O(INTRQ_OE_N_O), .IRQ_PEND_O(IRQ_PEND_O),
	.REG_WR_O(REG_WR_O), .PHASE_O(PHASE_O));

// ---- adhp_host_model.sv ----
// Behavioural host controller driving the device port cable
`timescale 1ns/100ps
module adhp_host_model (
	// Pacing clock and device drive
	input  wire logic        clk_i,
	input  wire logic [15:0] dev_dd_i,
	input  wire logic        dev_oe_n_i,
	input  wire logic        dev_rdy_i,
	input  wire logic        rdy_oe_n_i,
	input  wire logic        dmarq_i,
	// Host drive and resolved lines
	output logic             reset_n_o,
	output logic             diow_n_o,
	output logic             dior_n_o,
	output logic             dmack_n_o,
	output logic [1:0]       cs_n_o,
	output logic [2:0]       da_o,
	output wire logic [15:0] dd_o,
	output wire logic        rdy_o
);
	logic [15:0] hd;
	logic [15:0] last;
	logic [15:0] got[$];
	logic        hd_en = 1'h0;
	logic        cap_en = 1'h0;
	logic        seen = 1'h1;
	// Released bus shows a changing pattern, never a held value
	assign dd_o = !dev_oe_n_i ? dev_dd_i : hd_en ? hd : ~last;
	assign rdy_o = rdy_oe_n_i | dev_rdy_i; // Pull-up
	always @(posedge clk_i) last <= dd_o;
	// One word per device strobe edge, either direction
	always @(negedge clk_i) begin
		if (cap_en && rdy_o != seen) got.push_back(dd_o);
		seen = rdy_o;
	end
	// Reset held over power-up
	initial begin
		{reset_n_o, diow_n_o, dior_n_o, dmack_n_o, cs_n_o, da_o} = 9'h0F8;
		repeat (20) @(negedge clk_i);
		reset_n_o = 1'h1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Register or multiword strobe cycle; cs 2'h3 inside DMA
	task automatic cycle(input logic wr, input logic [1:0] cs,
			input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
		tick(1);
		cs_n_o = cs;
		da_o = a;
		hd = d;
		hd_en = wr; // Whole word offered
		tick(2);
		diow_n_o = !wr; // Strobe choice sets direction
		dior_n_o = wr;
		tick(6);
		for (int i = 0; i < 200 && !rdy_o; i++) tick(1);
		q = dd_o; // Taken as the read strobe rises
		diow_n_o = 1'h1;
		dior_n_o = 1'h1;
		tick(2);
		cs_n_o = 2'h3;
		hd_en = 1'h0;
		tick(4);
	endtask
	// Answer a request, then open a burst
	task automatic dma_begin(input logic ultra);
		for (int i = 0; i < 100 && !dmarq_i; i++) tick(1);
		diow_n_o = !ultra;
		dmack_n_o = 1'h0;
		tick(6);
	endtask
	// STOP on the write line closes the burst
	task automatic dma_end();
		diow_n_o = 1'h1;
		hd_en = 1'h0;
		tick(6);
		dmack_n_o = 1'h1;
		tick(8);
	endtask
	// Burst write word, paced by the device's ready
	task automatic udma_wr(input logic [15:0] w);
		for (int i = 0; i < 400 && rdy_o; i++) tick(1);
		hd = w;
		hd_en = 1'h1;
		tick(3);
		dior_n_o = !dior_n_o;
		tick(3);
	endtask
	// Burst read of n words, host ready throughout
	task automatic udma_rd(input int n);
		got.delete();
		cap_en = 1'h1;
		dior_n_o = 1'h0;
		for (int i = 0; i < 40 * n && got.size() < n; i++) tick(1);
		dior_n_o = 1'h1;
		cap_en = 1'h0;
	endtask
endmodule // adhp_host_model

// ---- test_ata_device_host_port.sv ----
// Self-checking bench for the device host port
`timescale 1ns/100ps
module test_ata_device_host_port;
	localparam int DEPTH = adhp_pkg::FIFO_DEPTH;
	logic             clk = 1'h0, rst = 1'h1, rx_ready = 1'h0, rx_hold = 1'h0;
	logic             dev_sel = 1'h0, irq_set = 1'h0, drq = 1'h1;
	logic             dma_en = 1'h0, dma_wr = 1'h0, udma = 1'h0;
	logic             tx_valid = 1'h0;
	logic [15:0]      tx_data = 16'h0000, q, w;
	logic [7:0]       reg_rdata = 8'h00, wdat;
	logic [3:0]       wloc;
	logic [15:0]      rx_exp[$], tx_exp[$];
	int               n_fail = 0, checks = 0, seed = 45094, n_wr = 0, i;
	wire logic [15:0] dd, dd_o, rx_data;
	wire logic [2:0]  da, reg_da;
	wire logic [1:0]  cs_n, phase;
	wire logic [7:0]  reg_wdata;
	wire logic        reset_n, diow_n, dior_n, dmack_n, dd_oe_n, dmarq, rdy;
	wire logic        rdy_pin, rdy_oe_n, intrq_o, intrq_oe_n, reg_wr, reg_cs1;
	wire logic        rx_valid, tx_ready;
	wire logic        intrq = !intrq_oe_n && intrq_o; // Pull-down

	always #5 clk = ~clk;

	adhp_host_port DUT (
		.CLK_I(clk), .RST_I(rst), .RESET_N_I(reset_n), .DIOW_N_I(diow_n),
		.DIOR_N_I(dior_n), .DMACK_N_I(dmack_n), .CS0_N_I(cs_n[0]),
		.CS1_N_I(cs_n[1]), .DA_I(da), .DD_I(dd), .DD_O(dd_o),
		.DD_OE_N_O(dd_oe_n), .DMARQ_O(dmarq), .IORDY_O(rdy_pin),
		.IORDY_OE_N_O(rdy_oe_n), .INTRQ_O(intrq_o), .INTRQ_OE_N_O(intrq_oe_n),
		.DEV_SEL_I(dev_sel), .IRQ_SET_I(irq_set), .DRQ_I(drq),
		.DMA_EN_I(dma_en), .DMA_WRITE_I(dma_wr), .UDMA_I(udma),
		.REG_WR_O(reg_wr), .REG_RD_O(), .REG_CS1_O(reg_cs1), .REG_DA_O(reg_da),
		.REG_WDATA_O(reg_wdata), .REG_RDATA_I(reg_rdata), .RX_DATA_O(rx_data),
		.RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .TX_DATA_I(tx_data),
		.TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .HOST_RESET_O(),
		.IRQ_PEND_O(), .PHASE_O(phase));
	adhp_host_model h (.clk_i(clk), .dev_dd_i(dd_o), .dev_oe_n_i(dd_oe_n),
		.dev_rdy_i(rdy_pin), .rdy_oe_n_i(rdy_oe_n), .dmarq_i(dmarq),
		.reset_n_o(reset_n), .diow_n_o(diow_n), .dior_n_o(dior_n),
		.dmack_n_o(dmack_n), .cs_n_o(cs_n), .da_o(da), .dd_o(dd), .rdy_o(rdy));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", n_fail, checks);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Outputs looked at mid-cycle, where they are settled; a word is
	// compared when the ready offered for the next edge will take it
	always @(negedge clk) begin : rx_side
		logic take;
		take = !rx_hold && 1'($random(seed));
		if (rx_valid && take)
			check(rx_data, rx_exp.pop_front());
		rx_ready <= take;
		if (reg_wr) begin
			n_wr <= n_wr + 1;
			wdat <= reg_wdata;
			wloc <= {reg_cs1, reg_da};
		end
	end
	// Whole run is under a thousand cycles; this leaves ample slack
	initial begin
		#400000;
		n_fail++;
		conclude();
	end
	initial begin
		reg_rdata = 8'($random(seed));
		repeat (16) @(negedge clk);
		rst = 1'h0;
		repeat (30) @(negedge clk);
		dev_sel = 1'h1;
		for (i = 0; i < 4; i++) begin
			w = 16'($random(seed));
			rx_exp.push_back(w);
			h.cycle(1'h1, 2'h2, 3'h0, w, q);
		end
		// Low byte only; second write re-enables the interrupt
		h.cycle(1'h1, 2'h1, 3'h6, 16'hFF02, q);
		check({12'h000, wloc}, 16'h000E);
		check({8'h00, wdat}, 16'h0002);
		check(16'(intrq_oe_n), 16'h0001);
		h.cycle(1'h1, 2'h1, 3'h6, 16'hFF00, q);
		check(16'(intrq_oe_n), 16'h0000);
		i = n_wr;
		h.cycle(1'h1, 2'h0, 3'h7, 16'h0000, q);
		check(16'(n_wr - i), 16'h0000);
		h.cycle(1'h0, 2'h2, 3'h1, 16'h0000, q);
		check(q, {8'h00, reg_rdata});
		// Status read, command write, request drop
		for (i = 0; i < 3; i++) begin
			irq_set = 1'h1;
			@(negedge clk);
			irq_set = 1'h0;
			repeat (2) @(negedge clk);
			check(16'(intrq), 16'h0001);
			if (i == 2)
				drq = 1'h0;
			else
				h.cycle(i[0], 2'h2, 3'h7, 16'h0000, q);
			repeat (3) @(negedge clk);
			check(16'(intrq), 16'h0000);
		end
		dma_en = 1'h1;
		repeat (2) @(negedge clk);
		check(16'(dmarq), 16'h0000);
		i = 0;
		while (i < 20 && tx_ready) begin
			w = 16'($random(seed));
			tx_data = w;
			tx_valid = 1'h1;
			tx_exp.push_back(w);
			@(negedge clk);
			i++;
		end
		tx_valid = 1'h0;
		check(16'(i), 16'(DEPTH));
		check(16'(dmarq), 16'h0001);
		h.cycle(1'h0, 2'h2, 3'h0, 16'h0000, q);
		check(q, tx_exp.pop_front());
		h.dma_begin(1'h0);
		check(16'(phase), 16'h0001);
		h.cycle(1'h0, 2'h3, 3'h0, 16'h0000, q);
		check(q, tx_exp.pop_front());
		h.dma_end();
		udma = 1'h1;
		h.dma_begin(1'h1);
		h.udma_rd(tx_exp.size());
		check(16'(h.got.size()), 16'(tx_exp.size()));
		for (i = 0; i < h.got.size(); i++) check(h.got[i], tx_exp[i]);
		h.dma_end();
		check(16'(dd_oe_n), 16'h0001);
		// Burst write into a stalled buffer until it pauses
		dma_wr = 1'h1;
		rx_hold = 1'h1;
		fork
			begin
				h.dma_begin(1'h1);
				for (i = 0; i < 16; i++) begin
					w = 16'($random(seed));
					rx_exp.push_back(w);
					h.udma_wr(w);
				end
				h.dma_end();
			end
			begin
				repeat (200) @(negedge clk);
				check(16'(rdy), 16'h0001);
				check(16'(phase), 16'h0002);
				rx_hold = 1'h0;
			end
		join
		udma = 1'h0;
		h.dma_begin(1'h0);
		for (i = 0; i < 2; i++) begin
			w = 16'($random(seed));
			rx_exp.push_back(w);
			h.cycle(1'h1, 2'h3, 3'h0, w, q);
		end
		h.dma_end();
		dma_en = 1'h0;
		for (i = 0; i < 500 && rx_exp.size() > 0; i++) @(negedge clk);
		check(16'(rx_exp.size()), 16'h0000);
		conclude();
	end
endmodule // test_ata_device_host_port
